// file: verif/ard_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none

module ard_pipe_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        fp_start,
  input  wire logic [3:0]  fp_len,
  input  wire logic        wb_valid,
  input  wire logic [4:0]  wb_index,
  input  wire logic [63:0] wb_data,
  input  wire logic [4:0]  peek_index,
  output var  logic [63:0] peek_data,
  output var  logic        fp_busy
);
  logic [63:0] rf [32];
  logic [3:0]  fp_left;

  assign fp_busy   = (fp_left != 4'h0);
  // Peek lets the bench see untouched entries after a trap
  assign peek_data = rf[peek_index];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fp_left <= 4'h0;
      for (int i = 0; i < 32; i++) rf[i] <= 64'h0;
    end else begin
      if (fp_start) fp_left <= fp_len;
      else if (fp_busy) fp_left <= fp_left - 4'h1;
      // write-back lands in the register file
      if (wb_valid) rf[wb_index] <= wb_data;
    end
  end
endmodule : ard_pipe_model

`default_nettype wire

// file: verif/ard_read_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ard_read_decode_tb;
  logic                sys_clk = 1'b0;
  logic                rst_b = 1'b0;
  logic [3:0]          avs_address = 4'h0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = 32'h0;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                issue_valid = 1'b0;
  logic [31:0]         instr = 32'h0;
  logic [63:0]         prog_ctr = 64'hfedc_ba98_7654_3210;
  logic                fp_busy;
  logic                fp_start = 1'b0;
  logic                issue_ready;
  logic [3:0]          fp_len = 4'h0;
  logic [63:0]         src [12];
  logic                wb_valid;
  logic                barrier_valid;
  logic                fault_valid;
  logic [4:0]          wb_index;
  logic [63:0]         wb_data;
  logic [63:0]         peek_data;
  logic [6:0]          barrier_mask;
  ard_pkg::ard_fault_t fault_code;
  logic [31:0]         q;
  int                  n_errors = 0;
  int                  total_checks = 0;
  int                  cyc = 0;
  int                  n_wait;
  int                  kind;

  always #20 sys_clk = ~sys_clk;

  ard_read_decode ard_read_decode_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .issue_valid(issue_valid), .instr(instr), .program_counter(prog_ctr),
    .fp_busy(fp_busy), .issue_ready(issue_ready),
    .mulhi_reg(src[0]), .ccr_reg(src[1][7:0]), .asi_reg(src[2][7:0]),
    .tick_reg(src[3]), .fprs_reg(src[4][7:0]), .pcr_reg(src[5]),
    .pic_reg(src[6]), .gsr_reg(src[7]), .softint_reg(src[8]),
    .tick_cmp_reg(src[9]), .stick_reg(src[10]), .stick_cmp_reg(src[11]),
    .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
    .barrier_valid(barrier_valid), .barrier_mask(barrier_mask),
    .fault_valid(fault_valid), .fault_code(fault_code)
  );

  ard_pipe_model ard_pipe_model_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .fp_start(fp_start),
    .fp_len(fp_len), .wb_valid(wb_valid), .wb_index(wb_index),
    .wb_data(wb_data), .peek_index(5'h09), .peek_data(peek_data),
    .fp_busy(fp_busy)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    // Ends when waitrequest drops; if it stays high only the bench timeout ends this wait
    do begin @(posedge sys_clk); end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic run_op(input logic [4:0] s, input logic [4:0] r,
                        input logic [13:0] lo);
    issue_valid <= 1'b1;
    instr       <= {2'b10, r, 6'h28, s, lo};
    do begin @(posedge sys_clk); end
    while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    n_wait = 0;
    do begin @(posedge sys_clk); n_wait++; end
    while (wb_valid !== 1'b1 && barrier_valid !== 1'b1
           && fault_valid !== 1'b1 && n_wait < 50);
    kind = (wb_valid === 1'b1) ? 0 : (barrier_valid === 1'b1) ? 1 :
           (fault_valid === 1'b1) ? 2 : 3;
  endtask : run_op

  // Kind 0 write-back, 1 barrier, 2 fault
  task automatic op(input logic [4:0] s, input logic [4:0] r,
                    input logic [13:0] lo, input int k,
                    input logic [63:0] e);
    run_op(s, r, lo);
    chk("latency", 64'h1, n_wait);
    chk("kind", k, kind);
    if (k == 0) begin
      chk("wb_index", r, wb_index);
      chk("wb_data", e, wb_data);
    end
    if (k == 1) chk("barrier_mask", e, barrier_mask);
    if (k == 2) chk("fault_code", e, fault_code);
  endtask : op

  function automatic logic [63:0] ex(input int k);
    return (k == 1 || k == 2 || k == 4) ? {56'h0, src[k][7:0]} : src[k];
  endfunction : ex

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_bus;
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", 64'h01, q);
    bus(1'b1, 4'hc, 32'hff);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", 64'h0, q);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl kept", 64'h01, q);
    $display("test bus done, errors %0d", n_errors);
  endtask : t_bus

  task automatic t_map;
    logic [4:0] sl [11] = '{0, 2, 3, 4, 16, 17, 19, 22, 23, 24, 25};
    int         ix [11] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11};
    bus(1'b1, 4'h0, 32'h1d);
    for (int k = 0; k < 4; k++)
      op(sl[k], 5'(k + 1), 14'h0, 0, ex(ix[k]));
    for (int k = 4; k < 11; k++)
      op(sl[k], 5'(k + 1), 14'h0, 0, ex(ix[k]));
    op(5'd5, 5'd20, 14'h0, 0, prog_ctr);
    bus(1'b1, 4'h0, 32'h1f);
    op(5'd5, 5'd21, 14'h0, 0, {32'h0, prog_ctr[31:0]});
    $display("test map done, errors %0d", n_errors);
  endtask : t_map

  task automatic t_bad;
    logic [4:0] bd [18] = '{1, 7, 8, 9, 10, 11, 12, 13, 14, 18, 20, 21,
                            26, 27, 28, 29, 30, 31};
    bus(1'b1, 4'h0, 32'h1d);
    op(5'd0, 5'd9, 14'h0, 0, src[0]);
    for (int k = 0; k < 18; k++)
      op(bd[k], 5'd9, 14'h0, 2, ard_pkg::FLT_BAD_ENC);
    op(5'd15, 5'd9, 14'h0, 2, ard_pkg::FLT_BAD_ENC);
    op(5'd15, 5'd0, 14'h005a, 1, 64'h5a);
    op(5'd2, 5'd9, 14'h0001, 2, ard_pkg::FLT_BAD_ENC);
    op(5'd2, 5'd9, 14'h2000, 2, ard_pkg::FLT_BAD_ENC);
    chk("kept dest", src[0], peek_data);
    $display("test reserved done, errors %0d", n_errors);
  endtask : t_bad

  task automatic t_priv;
    logic [4:0] ps [5] = '{16, 22, 23, 24, 25};
    logic [7:0] fo [3] = '{8'h19, 8'h15, 8'h0d};
    bus(1'b1, 4'h0, 32'h1c);
    for (int k = 0; k < 5; k++)
      op(ps[k], 5'd9, 14'h0, 2, ard_pkg::FLT_SUPV_OPC);
    op(5'd4, 5'd10, 14'h0, 0, src[3]);
    op(5'd17, 5'd11, 14'h0, 0, src[6]);
    bus(1'b1, 4'h0, 32'h3c);
    op(5'd4, 5'd9, 14'h0, 2, ard_pkg::FLT_SUPV_ACC);
    bus(1'b1, 4'h0, 32'h9c);
    op(5'd17, 5'd9, 14'h0, 2, ard_pkg::FLT_SUPV_ACC);
    bus(1'b1, 4'h0, 32'h5c);
    op(5'd24, 5'd9, 14'h0, 2, ard_pkg::FLT_SUPV_OPC);
    bus(1'b1, 4'h0, 32'h7d);
    op(5'd24, 5'd12, 14'h0, 0, src[10]);
    op(5'd4, 5'd13, 14'h0, 0, src[3]);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 4'h0, {24'h0, fo[k]});
      op(5'd19, 5'd9, 14'h0, 2, ard_pkg::FLT_FPU_OFF);
    end
    $display("test privilege done, errors %0d", n_errors);
  endtask : t_priv

  task automatic t_fp;
    bus(1'b0, 4'h4, 32'h0);
    chk("status", 64'h23, q);
    bus(1'b1, 4'h0, 32'h1d);
    bus(1'b1, 4'h8, 32'h0);
    fp_len   <= 4'h6;
    fp_start <= 1'b1;
    @(posedge sys_clk);
    fp_start <= 1'b0;
    run_op(5'd6, 5'd14, 14'h0);
    chk("fp drained", 64'h1, 64'(n_wait >= 6));
    chk("fprs data", ex(4), wb_data);
    op(5'd6, 5'd16, 14'h0, 0, ex(4));
    op(5'd3, 5'd15, 14'h0, 0, ex(2));
    bus(1'b0, 4'h8, 32'h0);
    chk("counts", 64'h3, q);
    $display("test fp wait done, errors %0d", n_errors);
  endtask : t_fp

  task end_of_test;
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // Cuts a hang short; a full run is well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    for (int i = 0; i < 12; i++)
      src[i] = {8'ha5 ^ 8'(i), 24'h13579b, 8'(i * 17 + 3), 24'h2468ac};
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_bus();
    t_map();
    t_bad();
    t_priv();
    t_fp();
    end_of_test();
  end
endmodule : ard_read_decode_tb

`default_nettype wire

// file: verilog/ard_params.svh
`ifndef ARD_PARAMS_SVH
`define ARD_PARAMS_SVH

// ********************************************************************
// Instruction fields
// ********************************************************************
`define ARD_RD_HI        29
`define ARD_RD_LO        25
`define ARD_SEL_HI       18
`define ARD_SEL_LO       14
`define ARD_LOW_HI       13
`define ARD_MASK_HI      6

// ********************************************************************
// Source selector values
// ********************************************************************
`define ARD_SEL_MULHI    5'h00
`define ARD_SEL_CCR      5'h02
`define ARD_SEL_ASI      5'h03
`define ARD_SEL_TICK     5'h04
`define ARD_SEL_PROG     5'h05
`define ARD_SEL_FPRS     5'h06
`define ARD_SEL_BARRIER  5'h0f
`define ARD_SEL_PCR      5'h10
`define ARD_SEL_PIC      5'h11
`define ARD_SEL_GSR      5'h13
`define ARD_SEL_SOFTINT  5'h16
`define ARD_SEL_TCMP     5'h17
`define ARD_SEL_STICK    5'h18
`define ARD_SEL_SCMP     5'h19

// ********************************************************************
// Register map (byte offsets)
// ********************************************************************
`define ARD_OFS_CTRL     4'h0
`define ARD_OFS_STATUS   4'h4
`define ARD_OFS_COUNT    4'h8

// ********************************************************************
// Control bit positions and reset
// ********************************************************************
`define ARD_CTRL_SUPV    0
`define ARD_CTRL_AM      1
`define ARD_CTRL_FEF     2
`define ARD_CTRL_PEF     3
`define ARD_CTRL_FPU     4
`define ARD_CTRL_TOFF    5
`define ARD_CTRL_SOFF    6
`define ARD_CTRL_PLOCK   7
`define ARD_CTRL_RST     8'h01

// ********************************************************************
// Status bit positions
// ********************************************************************
`define ARD_STAT_WAIT    4
`define ARD_STAT_READY   5

`endif

// file: verilog/ard_pkg.sv
`default_nettype none

package ard_pkg;

  // ******************************************************************
  // Fault kinds
  // ******************************************************************
  typedef enum logic [2:0] {
    FLT_NONE,
    FLT_BAD_ENC,
    FLT_SUPV_OPC,
    FLT_FPU_OFF,
    FLT_SUPV_ACC
  } ard_fault_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_FP_WAIT
  } ard_state_t;

  // ******************************************************************
  // Whole state of the decoder
  // ******************************************************************
  typedef struct packed {
    ard_state_t  state;
    logic        issue_ready;
    logic        wb_valid;
    logic [4:0]  wb_index;
    logic [63:0] wb_data;
    logic        barrier_valid;
    logic [6:0]  barrier_mask;
    logic        fault_valid;
    ard_fault_t  fault_code;
    ard_fault_t  last_fault;
    logic [4:0]  pend_index;
    logic [7:0]  ctrl;
    logic [15:0] read_count;
    logic [15:0] fault_count;
    logic        waitrequest;
    logic [31:0] readdata;
  } ard_regs_t;

endpackage : ard_pkg

`default_nettype wire

// file: verilog/ard_read_decode.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ard_params.svh"

module ard_read_decode (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [31:0]       avs_readdata,
  output var  logic              avs_waitrequest,
  // Pipeline issue
  input  wire logic              issue_valid,
  input  wire logic [31:0]       instr,
  input  wire logic [63:0]       program_counter,
  input  wire logic              fp_busy,
  output var  logic              issue_ready,
  // State register sources
  input  wire logic [63:0]       mulhi_reg,
  input  wire logic [7:0]        ccr_reg,
  input  wire logic [7:0]        asi_reg,
  input  wire logic [63:0]       tick_reg,
  input  wire logic [7:0]        fprs_reg,
  input  wire logic [63:0]       pcr_reg,
  input  wire logic [63:0]       pic_reg,
  input  wire logic [63:0]       gsr_reg,
  input  wire logic [63:0]       softint_reg,
  input  wire logic [63:0]       tick_cmp_reg,
  input  wire logic [63:0]       stick_reg,
  input  wire logic [63:0]       stick_cmp_reg,
  // Register file write-back
  output var  logic              wb_valid,
  output var  logic [4:0]        wb_index,
  output var  logic [63:0]       wb_data,
  // Barrier and trap
  output var  logic              barrier_valid,
  output var  logic [6:0]        barrier_mask,
  output var  logic              fault_valid,
  output var  ard_pkg::ard_fault_t fault_code
);

  ard_pkg::ard_regs_t  r;
  ard_pkg::ard_regs_t  next_r;
  ard_pkg::ard_fault_t dec_fault;
  logic                dec_barrier;
  logic                dec_fp_wait;
  logic [4:0]          sel;
  logic [4:0]          rd;
  logic                accept;

  assign sel    = instr[`ARD_SEL_HI:`ARD_SEL_LO];
  assign rd     = instr[`ARD_RD_HI:`ARD_RD_LO];
  assign accept = issue_valid && r.issue_ready &&
                  (r.state == ard_pkg::ST_IDLE);

  // ******************************************************************
  // Selector decode and fault classification
  // ******************************************************************
  ard_sel_decode u_dec (
    .sel        (sel),
    .rd         (rd),
    .low_bits   (instr[`ARD_LOW_HI:0]),
    .supervisor (r.ctrl[`ARD_CTRL_SUPV]),
    .fpu_on     (r.ctrl[`ARD_CTRL_FEF] && r.ctrl[`ARD_CTRL_PEF] &&
                 r.ctrl[`ARD_CTRL_FPU]),
    .tick_off   (r.ctrl[`ARD_CTRL_TOFF]),
    .stick_off  (r.ctrl[`ARD_CTRL_SOFF]),
    .pic_lock   (r.ctrl[`ARD_CTRL_PLOCK]),
    .fault      (dec_fault),
    .barrier    (dec_barrier),
    .fp_wait    (dec_fp_wait)
  );

  // ******************************************************************
  // Source multiplexer
  // ******************************************************************
  function automatic logic [63:0] read_value(input logic [4:0] s,
                                             input logic am);
    logic [63:0] v;
    v = 64'h0;
    case (s)
      `ARD_SEL_MULHI:   v = mulhi_reg;
      `ARD_SEL_CCR:     v = {56'h0, ccr_reg};
      `ARD_SEL_ASI:     v = {56'h0, asi_reg};
      `ARD_SEL_TICK:    v = tick_reg;
      `ARD_SEL_PROG:    v = am ? {32'h0, program_counter[31:0]}
                               : program_counter;
      `ARD_SEL_FPRS:    v = {56'h0, fprs_reg};
      `ARD_SEL_PCR:     v = pcr_reg;
      `ARD_SEL_PIC:     v = pic_reg;
      `ARD_SEL_GSR:     v = gsr_reg;
      `ARD_SEL_SOFTINT: v = softint_reg;
      `ARD_SEL_TCMP:    v = tick_cmp_reg;
      `ARD_SEL_STICK:   v = stick_reg;
      `ARD_SEL_SCMP:    v = stick_cmp_reg;
      default:          v = 64'h0;
    endcase
    return v;
  endfunction : read_value

  function automatic logic [31:0] bus_view(input logic [3:0] a,
                                           input ard_pkg::ard_regs_t s);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `ARD_OFS_CTRL:   v = {24'h0, s.ctrl};
      `ARD_OFS_STATUS: begin
        v[2:0]            = s.last_fault;
        v[`ARD_STAT_WAIT]  = (s.state == ard_pkg::ST_FP_WAIT);
        v[`ARD_STAT_READY] = s.issue_ready;
      end
      `ARD_OFS_COUNT:  v = {s.fault_count, s.read_count};
      // Unmapped reads return zero
      default:         v = 32'h0;
    endcase
    return v;
  endfunction : bus_view

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    next_r               = r;
    next_r.wb_valid      = 1'b0;
    next_r.barrier_valid = 1'b0;
    next_r.fault_valid   = 1'b0;
    next_r.waitrequest   = 1'b1;

    // One wait state: answer registered, taken next edge
    if ((avs_read || avs_write) && r.waitrequest) begin
      next_r.waitrequest = 1'b0;
      next_r.readdata    = bus_view(avs_address, r);
    end
    if (avs_write && !r.waitrequest) begin
      case (avs_address)
        `ARD_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            next_r.ctrl = avs_writedata[7:0];
          end
        end
        `ARD_OFS_COUNT: begin
          next_r.read_count  = 16'h0000;
          next_r.fault_count = 16'h0000;
        end
        default: begin
          next_r.ctrl = r.ctrl;
        end
      endcase
    end

    // Counts below override a same-cycle clear
    case (r.state)
      ard_pkg::ST_IDLE: begin
        if (accept) begin
          if (dec_fault != ard_pkg::FLT_NONE) begin
            next_r.fault_valid = 1'b1;
            next_r.fault_code  = dec_fault;
            next_r.last_fault  = dec_fault;
            next_r.fault_count = r.fault_count + 16'h0001;
          end else if (dec_barrier) begin
            next_r.barrier_valid = 1'b1;
            next_r.barrier_mask  = instr[`ARD_MASK_HI:0];
          end else if (dec_fp_wait && fp_busy) begin
            next_r.state       = ard_pkg::ST_FP_WAIT;
            next_r.issue_ready = 1'b0;
            next_r.pend_index  = rd;
          end else begin
            next_r.wb_valid   = 1'b1;
            next_r.wb_index   = rd;
            next_r.wb_data    = read_value(sel, r.ctrl[`ARD_CTRL_AM]);
            next_r.read_count = r.read_count + 16'h0001;
          end
        end
      end
      ard_pkg::ST_FP_WAIT: begin
        if (!fp_busy) begin
          next_r.state       = ard_pkg::ST_IDLE;
          next_r.issue_ready = 1'b1;
          next_r.wb_valid    = 1'b1;
          next_r.wb_index    = r.pend_index;
          next_r.wb_data     = read_value(`ARD_SEL_FPRS, 1'b0);
          next_r.read_count  = r.read_count + 16'h0001;
        end
      end
      default: begin
        next_r.state       = ard_pkg::ST_IDLE;
        next_r.issue_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r             <= '0;
      r.state       <= ard_pkg::ST_IDLE;
      r.issue_ready <= 1'b1;
      r.waitrequest <= 1'b1;
      r.ctrl        <= `ARD_CTRL_RST;
      r.fault_code  <= ard_pkg::FLT_NONE;
      r.last_fault  <= ard_pkg::FLT_NONE;
    end else begin
      r <= next_r;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign avs_readdata    = r.readdata;
  assign avs_waitrequest = r.waitrequest;
  assign issue_ready     = r.issue_ready;
  assign wb_valid        = r.wb_valid;
  assign wb_index        = r.wb_index;
  assign wb_data         = r.wb_data;
  assign barrier_valid   = r.barrier_valid;
  assign barrier_mask    = r.barrier_mask;
  assign fault_valid     = r.fault_valid;
  assign fault_code      = r.fault_code;

  // ******************************************************************
  // Checks
  // ******************************************************************
  // no write on fault
  a_fault_no_wb: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    fault_valid |-> !wb_valid && !barrier_valid)
    else $error("write-back alongside fault");

  a_prog_masked: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && sel == `ARD_SEL_PROG && instr[13:0] == 14'h0 &&
    r.ctrl[`ARD_CTRL_AM]
    |=> wb_valid && wb_data[63:32] == 32'h0 &&
        wb_data[31:0] == $past(program_counter[31:0]))
    else $error("masked address read wrong");

  a_prog_full: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && sel == `ARD_SEL_PROG && instr[13:0] == 14'h0 &&
    !r.ctrl[`ARD_CTRL_AM]
    |=> wb_valid && wb_data == $past(program_counter) &&
        wb_index == $past(rd))
    else $error("full address read wrong");

  a_fp_stall: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && dec_fault == ard_pkg::FLT_NONE && dec_fp_wait && fp_busy
    |=> !issue_ready && !wb_valid && !fault_valid)
    else $error("fpu status read did not stall");

  a_fp_release: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    r.state == ard_pkg::ST_FP_WAIT && !fp_busy
    |=> wb_valid && issue_ready && wb_data == {56'h0, $past(fprs_reg)})
    else $error("fpu status read not completed");

  a_low_bits: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && sel != `ARD_SEL_BARRIER && instr[13:0] != 14'h0
    |=> fault_valid && fault_code == ard_pkg::FLT_BAD_ENC)
    else $error("nonzero low bits not faulted");

  a_barrier_split: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && sel == `ARD_SEL_BARRIER
    |=> $past(rd == 5'h00) ? barrier_valid
                           : fault_valid)
    else $error("barrier decode wrong");

  a_reserved_sel: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && (sel == 5'h01 || sel == 5'h12 || sel == 5'h1a)
    |=> fault_valid && fault_code == ard_pkg::FLT_BAD_ENC && !wb_valid)
    else $error("reserved selector accepted");

  a_supv_opc: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && sel == `ARD_SEL_PCR && instr[13:0] == 14'h0 &&
    !r.ctrl[`ARD_CTRL_SUPV]
    |=> fault_valid && fault_code == ard_pkg::FLT_SUPV_OPC)
    else $error("user pcr read not faulted");

  a_fpu_off: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    accept && sel == `ARD_SEL_GSR && instr[13:0] == 14'h0 &&
    !(r.ctrl[`ARD_CTRL_FEF] && r.ctrl[`ARD_CTRL_PEF])
    |=> fault_valid && fault_code == ard_pkg::FLT_FPU_OFF)
    else $error("graphics read with fpu off");

  // Bus answers in one wait state
  a_bus_answer: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

endmodule : ard_read_decode

`default_nettype wire

// file: verilog/ard_sel_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "ard_params.svh"

module ard_sel_decode (
  input  wire logic [4:0]        sel,
  input  wire logic [4:0]        rd,
  input  wire logic [13:0]       low_bits,
  input  wire logic              supervisor,
  input  wire logic              fpu_on,
  input  wire logic              tick_off,
  input  wire logic              stick_off,
  input  wire logic              pic_lock,
  output var  ard_pkg::ard_fault_t fault,
  output var  logic              barrier,
  output var  logic              fp_wait
);

  always_comb begin
    fault   = ard_pkg::FLT_NONE;
    barrier = 1'b0;
    fp_wait = 1'b0;
    if (sel == `ARD_SEL_BARRIER) begin
      if (rd != 5'h00) begin
        fault = ard_pkg::FLT_BAD_ENC;
      end else begin
        barrier = 1'b1;
      end
    end else if (low_bits != 14'h0000) begin
      fault = ard_pkg::FLT_BAD_ENC;
    end else begin
      case (sel)
        `ARD_SEL_MULHI, `ARD_SEL_CCR, `ARD_SEL_ASI, `ARD_SEL_PROG: begin
          fault = ard_pkg::FLT_NONE;
        end
        `ARD_SEL_TICK: begin
          if (!supervisor && tick_off) begin
            fault = ard_pkg::FLT_SUPV_ACC;
          end
        end
        `ARD_SEL_FPRS: begin
          fp_wait = 1'b1;
        end
        `ARD_SEL_PCR, `ARD_SEL_SOFTINT, `ARD_SEL_TCMP, `ARD_SEL_SCMP: begin
          if (!supervisor) begin
            fault = ard_pkg::FLT_SUPV_OPC;
          end
        end
        `ARD_SEL_STICK: begin
          if (!supervisor) begin
            fault = stick_off ? ard_pkg::FLT_SUPV_OPC : ard_pkg::FLT_SUPV_OPC;
          end
        end
        `ARD_SEL_PIC: begin
          if (!supervisor && pic_lock) begin
            fault = ard_pkg::FLT_SUPV_ACC;
          end
        end
        `ARD_SEL_GSR: begin
          if (!fpu_on) begin
            fault = ard_pkg::FLT_FPU_OFF;
          end
        end
        default: begin
          fault = ard_pkg::FLT_BAD_ENC;
        end
      endcase
    end
  end

endmodule : ard_sel_decode

`default_nettype wire
